//--- gain_settle.sv
// pending flag that stays up for a fixed settle time after each kick
`timescale 1ns/1ns
module gain_settle
    import mixer_regs_pkg::*;
#(
    parameter int CYCLES = SETTLE_CYC
) (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic kick, // new gain written
    output logic busy // gain not yet applied
);
    logic [CNT_W-1:0] cnt_ff; // cycles left to settle
    logic busy_ff; // pending flag

    // a kick always restarts the wait, so a write never gets lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= CNT_W'(CYCLES); // reset gains also need to settle
        end else if (kick) begin
            cnt_ff <= CNT_W'(CYCLES); // R16
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // flag drops with the last count, set wins over the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_ff <= 1'b1;
        end else if (kick) begin
            busy_ff <= 1'b1; // R16
        end else if (cnt_ff <= CNT_W'(1)) begin
            busy_ff <= 1'b0; // R16
        end
    end

    assign busy = busy_ff;
endmodule

//--- mixer_regs_checker.sv
// port assertions for the mixer register bank
`timescale 1ns/1ns
module mixer_regs_checker
    import mixer_regs_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int PWRUP_CYCLES = PWRUP_CYC
) (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic [ADDR_W-1:0] reg_addr, // offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire logic mono_pwr_req, // mono power request
    input wire route_vol_t [NUM_ROUTES-1:0] route_cfg, // routes
    input wire hp_level_t rcom_level, // headphone fields
    input wire mono_level_t mono_level, // mono fields
    input wire logic rcom_pending, // headphone pending
    input wire logic mono_pending, // mono pending
    input wire logic rcom_powered, // headphone powered
    input wire logic mono_powered // mono powered
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic hp_kick; // write that restarts headphone settling
    logic mono_kick; // write that restarts mono settling
    int hp_cnt_ff; // cycles since headphone kick, saturating
    int mono_cnt_ff; // cycles since mono kick, saturating
    assign hp_kick = reg_wr && (reg_addr == OFF_RDAC_RCOM || reg_addr == OFF_RCOM_LVL);
    assign mono_kick = reg_wr && reg_addr >= OFF_SECOND_LEFT_LINE_INPUT_MONO && reg_addr <= OFF_MONO_LVL;
    // reset counts as a kick, since pending starts high
    always_ff @(posedge mclk) begin
        if (rst || hp_kick) begin
            hp_cnt_ff <= 0;
        end else if (hp_cnt_ff < SETTLE_CYCLES) begin
            hp_cnt_ff <= hp_cnt_ff + 1;
        end
    end
    // saturating so a long idle cannot wrap back into pending
    always_ff @(posedge mclk) begin
        if (rst || mono_kick) begin
            mono_cnt_ff <= 0;
        end else if (mono_cnt_ff < SETTLE_CYCLES) begin
            mono_cnt_ff <= mono_cnt_ff + 1;
        end
    end
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    property p_route_rd;
        s_rd(OFF_RDAC_RCOM) |=> reg_rdata == $past(route_cfg[0]);
    endproperty
    property p_route_wr;
        s_wr(OFF_SECOND_LEFT_LINE_INPUT_MONO) |=> route_cfg[1] == $past(reg_wdata);
    endproperty
    property p_hp_wr;
        s_wr(OFF_RCOM_LVL) |=> rcom_level == {$past(reg_wdata[7:2]), $past(reg_wdata[0])};
    endproperty
    property p_mono_wr;
        s_wr(OFF_MONO_LVL) |=> mono_level == $past(reg_wdata[7:3]);
    endproperty
    property p_hp_rd;
        s_rd(OFF_RCOM_LVL) |=> reg_rdata == {$past(rcom_level[6:1]), $past(rcom_pending),
            $past(rcom_level.power_on)};
    endproperty
    property p_mono_rd;
        s_rd(OFF_MONO_LVL) |=> reg_rdata == {$past(mono_level), 1'h0, $past(mono_pending),
            $past(mono_powered)};
    endproperty
    property p_unmapped;
        reg_rd && (reg_addr < OFF_RDAC_RCOM || reg_addr > OFF_SECOND_LEFT_LINE_INPUT_LLINE) |=> reg_rdata == 8'h00;
    endproperty
    property p_hp_pend;
        rcom_pending == (hp_cnt_ff < SETTLE_CYCLES);
    endproperty
    property p_mono_pend;
        mono_pending == (mono_cnt_ff < SETTLE_CYCLES);
    endproperty
    // each output on its own, so one stuck ramp cannot hide behind the other
    property p_pwr_off;
        !mono_pwr_req |=> !mono_powered;
    endproperty
    property p_hp_pwr_off;
        !rcom_level.power_on |=> !rcom_powered;
    endproperty
    a_route_rd: assert property (p_route_rd) else $error("route read wrong");
    a_route_wr: assert property (p_route_wr) else $error("route write lost");
    a_hp_wr: assert property (p_hp_wr) else $error("hp fields wrong");
    a_mono_wr: assert property (p_mono_wr) else $error("mono fields wrong");
    a_hp_rd: assert property (p_hp_rd) else $error("hp read wrong");
    a_mono_rd: assert property (p_mono_rd) else $error("mono read wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hp_pend: assert property (p_hp_pend) else $error("hp pending wrong");
    a_mono_pend: assert property (p_mono_pend) else $error("mono pending wrong");
    a_pwr_off: assert property (p_pwr_off) else $error("mono powered without request");
    a_hp_pwr_off: assert property (p_hp_pwr_off) else $error("hp powered without request");
endmodule
bind output_mixer_route_level_regs mixer_regs_checker #(.SETTLE_CYCLES(SETTLE_CYCLES),
    .PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mono_pwr_req(mono_pwr_req), .route_cfg(route_cfg), .rcom_level(rcom_level),
    .mono_level(mono_level), .rcom_pending(rcom_pending), .mono_pending(mono_pending),
    .rcom_powered(rcom_powered), .mono_powered(mono_powered));

//--- mixer_regs_pkg.sv
// constants, field layouts and carrier types for the output mixer register bank
// Functional notes
// R01: routing bit D7 connects source to output
// R02: D6-D0 hold 7-bit volume, reset zero
// R03: common headphone level D7-D4, 1 dB steps
// R04: software never writes level codes 1010-1111
// R05: headphone D3 mutes at 0, resets muted
// R06: headphone D2 picks powered-down drive, resets 1
// R07: headphone D1 reads gain pending, resets 1
// R08: headphone D0 powers output up, resets 0
// R09: mono level D7-D4, same steps, resets 0 dB
// R10: mono D3 mutes at 0, resets muted
// R11: mono D2 reserved, reads zero
// R12: mono D1 reads gain pending, resets 1
// R13: mono D0 read-only powered status, resets 0
// R14: offsets 73-78 route six sources into mono
// R15: offset 80 routes second left input leftward
// R16: volume or level writes set pending until settled
package mixer_regs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_ROUTES = 8;

    // register offsets
    localparam logic [7:0] OFF_RDAC_RCOM = 8'h47;
    localparam logic [7:0] OFF_RCOM_LVL = 8'h48;
    localparam logic [7:0] OFF_SECOND_LEFT_LINE_INPUT_MONO = 8'h49;
    localparam logic [7:0] OFF_LAMP_MONO = 8'h4A;
    localparam logic [7:0] OFF_LDAC_MONO = 8'h4B;
    localparam logic [7:0] OFF_SECOND_RIGHT_LINE_INPUT_MONO = 8'h4C;
    localparam logic [7:0] OFF_RAMP_MONO = 8'h4D;
    localparam logic [7:0] OFF_RDAC_MONO = 8'h4E;
    localparam logic [7:0] OFF_MONO_LVL = 8'h4F;
    localparam logic [7:0] OFF_SECOND_LEFT_LINE_INPUT_LLINE = 8'h50;

    // route slot order, slot 0 first in the low byte
    localparam logic [NUM_ROUTES*8-1:0] ROUTE_OFFS = {
        OFF_SECOND_LEFT_LINE_INPUT_LLINE, OFF_RDAC_MONO, OFF_RAMP_MONO, OFF_SECOND_RIGHT_LINE_INPUT_MONO,
        OFF_LDAC_MONO, OFF_LAMP_MONO, OFF_SECOND_LEFT_LINE_INPUT_MONO, OFF_RDAC_RCOM};
    localparam logic [2:0] SLOT_RCOM = 3'h0;
    localparam logic [2:0] SLOT_LLINE = 3'h7;

    // field positions
    localparam int ROUTE_EN_BIT = 7;
    localparam int VOL_MSB = 6;
    localparam int LVL_MSB = 7;
    localparam int LVL_LSB = 4;
    localparam int MUTE_BIT = 3;
    localparam int PDDRV_BIT = 2;
    localparam int PEND_BIT = 1;
    localparam int PWR_BIT = 0;

    // reset values and the top level code
    localparam logic [6:0] VOL_RST = 7'h00;
    localparam logic [3:0] LVL_RST = 4'h0;
    localparam logic [3:0] LVL_MAX = 4'h9;
    localparam logic PDDRV_RST = 1'b1;

    // timing at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_NS = 10000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int PWRUP_NS = 20000;
    localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;

    typedef struct packed {
        logic en;
        logic [6:0] vol;
    } route_vol_t;

    typedef struct packed {
        logic [3:0] level;
        logic unmute;
        logic hiz_pd;
        logic power_on;
    } hp_level_t;

    typedef struct packed {
        logic [3:0] level;
        logic unmute;
    } mono_level_t;

endpackage

//--- output_mixer_route_level_regs.sv
// register bank for common headphone, mono and left line mixer controls
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module output_mixer_route_level_regs
    import mixer_regs_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int PWRUP_CYCLES = PWRUP_CYC
) (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic [ADDR_W-1:0] reg_addr, // register offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    input wire logic mono_pwr_req, // mono output power-up request
    output route_vol_t [NUM_ROUTES-1:0] route_cfg, // per-path switch and volume
    output hp_level_t rcom_level, // common headphone settings
    output mono_level_t mono_level, // mono line settings
    output logic rcom_pending, // headphone gain still settling
    output logic mono_pending, // mono gain still settling
    output logic rcom_powered, // headphone fully powered
    output logic mono_powered // mono fully powered
);

    // true when the offset names a routing register
    function automatic logic is_route(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_ROUTES; i++) begin
            if (a == ROUTE_OFFS[i*8 +: 8]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // slot number of a routing register, zero when none
    function automatic logic [2:0] route_slot(input logic [ADDR_W-1:0] a);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 0; i < NUM_ROUTES; i++) begin
            if (a == ROUTE_OFFS[i*8 +: 8]) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    // decoded access
    logic wr_route; // write hits a routing register
    logic [2:0] wr_slot; // which routing register
    logic wr_rcom_lvl; // write hits headphone level
    logic wr_mono_lvl; // write hits mono level
    logic rcom_kick; // headphone gain changed
    logic mono_kick; // mono gain changed

    // stored fields
    route_vol_t route_ff [NUM_ROUTES]; // routing registers
    logic [3:0] rcom_lvl_ff; // headphone level code
    logic rcom_unmute_ff; // headphone mute control
    logic rcom_hiz_ff; // headphone powered-down drive
    logic rcom_pwr_ff; // headphone power control
    logic [3:0] mono_lvl_ff; // mono level code
    logic mono_unmute_ff; // mono mute control

    // status from the helpers
    logic rcom_busy; // headphone settle in progress
    logic mono_busy; // mono settle in progress
    logic rcom_up; // headphone ramp done
    logic mono_up; // mono ramp done

    // read path
    logic [DATA_W-1:0] nxt_rdata; // value for the next cycle
    logic [DATA_W-1:0] rdata_ff; // registered read data

    // address decode for writes
    always_comb begin
        wr_route = reg_wr && is_route(reg_addr);
        wr_slot = route_slot(reg_addr);
        wr_rcom_lvl = reg_wr && (reg_addr == OFF_RCOM_LVL);
        wr_mono_lvl = reg_wr && (reg_addr == OFF_MONO_LVL);
    end

    // routing registers, one per source-to-output path
    for (genvar g = 0; g < NUM_ROUTES; g++) begin : g_route
        always_ff @(posedge mclk) begin
            if (rst) begin
                route_ff[g].en <= 1'b0; // R01
                route_ff[g].vol <= VOL_RST; // R02
            end else if (wr_route && (wr_slot == 3'(g))) begin
                // switch bit connects the source when set
                route_ff[g].en <= reg_wdata[ROUTE_EN_BIT]; // R01
                // volume code is taken whole, no range check
                route_ff[g].vol <= reg_wdata[VOL_MSB:0]; // R02
            end
        end
        // slots 1 to 6 feed mono, slot 7 the left line, slot 0 the headphone
        assign route_cfg[g] = route_ff[g]; // R14 R15
    end

    // headphone level field
    // reserved codes are stored as written: software must keep out of them
    always_ff @(posedge mclk) begin
        if (rst) begin
            rcom_lvl_ff <= LVL_RST; // R03
        end else if (wr_rcom_lvl) begin
            rcom_lvl_ff <= reg_wdata[LVL_MSB:LVL_LSB]; // R03 R04
        end
    end

    // headphone mute, starts muted
    always_ff @(posedge mclk) begin
        if (rst) begin
            rcom_unmute_ff <= 1'b0; // R05
        end else if (wr_rcom_lvl) begin
            rcom_unmute_ff <= reg_wdata[MUTE_BIT]; // R05
        end
    end

    // headphone powered-down drive, starts high impedance
    always_ff @(posedge mclk) begin
        if (rst) begin
            rcom_hiz_ff <= PDDRV_RST; // R06
        end else if (wr_rcom_lvl) begin
            rcom_hiz_ff <= reg_wdata[PDDRV_BIT]; // R06
        end
    end

    // headphone power control, starts off
    always_ff @(posedge mclk) begin
        if (rst) begin
            rcom_pwr_ff <= 1'b0; // R08
        end else if (wr_rcom_lvl) begin
            rcom_pwr_ff <= reg_wdata[PWR_BIT]; // R08
        end
    end

    // mono level field, same encoding as the headphone
    always_ff @(posedge mclk) begin
        if (rst) begin
            mono_lvl_ff <= LVL_RST; // R09
        end else if (wr_mono_lvl) begin
            mono_lvl_ff <= reg_wdata[LVL_MSB:LVL_LSB]; // R09 R04
        end
    end

    // mono mute, starts muted; bits D2 to D0 of a write are dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            mono_unmute_ff <= 1'b0; // R10
        end else if (wr_mono_lvl) begin
            mono_unmute_ff <= reg_wdata[MUTE_BIT]; // R10 R11
        end
    end

    // gain changes per output: any volume or level write restarts settling
    // the left line slot has its status elsewhere, so it kicks nothing here
    always_comb begin
        rcom_kick = wr_rcom_lvl || (wr_route && (wr_slot == SLOT_RCOM));
        mono_kick = wr_mono_lvl
            || (wr_route && (wr_slot != SLOT_RCOM) && (wr_slot != SLOT_LLINE));
    end

    // headphone settle timer
    gain_settle #(
        .CYCLES(SETTLE_CYCLES)
    ) u_rcom_settle (
        .mclk(mclk),
        .rst(rst),
        .kick(rcom_kick), // R16
        .busy(rcom_busy)
    );

    // mono settle timer
    gain_settle #(
        .CYCLES(SETTLE_CYCLES)
    ) u_mono_settle (
        .mclk(mclk),
        .rst(rst),
        .kick(mono_kick), // R16
        .busy(mono_busy)
    );

    // headphone ramps up while software holds its power bit
    power_ramp #(
        .CYCLES(PWRUP_CYCLES)
    ) u_rcom_pwr (
        .mclk(mclk),
        .rst(rst),
        .req(rcom_pwr_ff),
        .up(rcom_up)
    );

    // mono ramps up on the external power request
    power_ramp #(
        .CYCLES(PWRUP_CYCLES)
    ) u_mono_pwr (
        .mclk(mclk),
        .rst(rst),
        .req(mono_pwr_req),
        .up(mono_up)
    );

    // read mux, unmapped offsets read zero
    always_comb begin
        nxt_rdata = '0;
        if (is_route(reg_addr)) begin
            nxt_rdata = route_ff[route_slot(reg_addr)]; // R01 R02
        end else if (reg_addr == OFF_RCOM_LVL) begin
            nxt_rdata[LVL_MSB:LVL_LSB] = rcom_lvl_ff; // R03
            nxt_rdata[MUTE_BIT] = rcom_unmute_ff; // R05
            nxt_rdata[PDDRV_BIT] = rcom_hiz_ff; // R06
            nxt_rdata[PEND_BIT] = rcom_busy; // R07
            nxt_rdata[PWR_BIT] = rcom_pwr_ff; // R08
        end else if (reg_addr == OFF_MONO_LVL) begin
            nxt_rdata[LVL_MSB:LVL_LSB] = mono_lvl_ff; // R09
            nxt_rdata[MUTE_BIT] = mono_unmute_ff; // R10
            nxt_rdata[PDDRV_BIT] = 1'b0; // R11
            nxt_rdata[PEND_BIT] = mono_busy; // R12
            nxt_rdata[PWR_BIT] = mono_up; // R13
        end
    end

    // read data register; held between reads to keep the bus quiet
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs toward the analog mixers
    assign reg_rdata = rdata_ff;
    assign rcom_level.level = rcom_lvl_ff;
    assign rcom_level.unmute = rcom_unmute_ff;
    assign rcom_level.hiz_pd = rcom_hiz_ff;
    assign rcom_level.power_on = rcom_pwr_ff;
    assign mono_level.level = mono_lvl_ff;
    assign mono_level.unmute = mono_unmute_ff;
    assign rcom_pending = rcom_busy; // R07
    assign mono_pending = mono_busy; // R12
    assign rcom_powered = rcom_up;
    assign mono_powered = mono_up; // R13

endmodule

//--- power_ramp.sv
// reports full power only after the request has held for the ramp time
`timescale 1ns/1ns
module power_ramp
    import mixer_regs_pkg::*;
#(
    parameter int CYCLES = PWRUP_CYC
) (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic req, // power-up wanted
    output logic up // output fully powered
);
    logic [CNT_W-1:0] cnt_ff; // cycles of ramp done
    logic up_ff; // powered status

    // any drop of the request restarts the ramp from zero
    always_ff @(posedge mclk) begin
        if (rst || !req) begin
            cnt_ff <= '0;
        end else if (cnt_ff != CNT_W'(CYCLES)) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // status only rises once the whole ramp has run
    always_ff @(posedge mclk) begin
        if (rst || !req) begin
            up_ff <= 1'b0;
        end else begin
            up_ff <= (cnt_ff == CNT_W'(CYCLES));
        end
    end

    assign up = up_ff;
endmodule

//--- tb.sv
// self-checking bench for the mixer register bank
`timescale 1ns/1ns
module tb;
    import mixer_regs_pkg::*;
    localparam int SC = 4; // short settle time
    localparam int PC = 4; // short power ramp
    logic mclk = 1'h0; // clock
    logic rst = 1'h1; // reset
    logic reg_wr = 1'h0; // write strobe
    logic reg_rd = 1'h0; // read strobe
    logic mono_pwr_req = 1'h0; // mono power request
    logic [7:0] reg_addr = 8'h00; // offset
    logic [7:0] reg_wdata = 8'h00; // write data
    logic [7:0] reg_rdata; // read data
    logic [7:0] v; // last read value
    route_vol_t [NUM_ROUTES-1:0] route_cfg; // route outputs
    hp_level_t rcom_level; // headphone fields
    mono_level_t mono_level; // mono fields
    logic rcom_pending, mono_pending, rcom_powered, mono_powered; // status
    logic [7:0] mdl [0:9]; // expected stored bytes, 0x47 first
    int n_errors = 0; // mismatches
    int n_checks = 0; // comparisons
    int cyc = 0; // cycles run
    output_mixer_route_level_regs #(.SETTLE_CYCLES(SC), .PWRUP_CYCLES(PC)) u_dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mono_pwr_req(mono_pwr_req),
        .route_cfg(route_cfg), .rcom_level(rcom_level), .mono_level(mono_level),
        .rcom_pending(rcom_pending), .mono_pending(mono_pending),
        .rcom_powered(rcom_powered), .mono_powered(mono_powered));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // a hang counts as a mismatch; the run needs well under this
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: timeout", $time);
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // status bits are timed, so register compares leave them out
    function automatic logic [7:0] msk(input logic [7:0] a);
        return (a == OFF_RCOM_LVL) ? 8'hFD : (a == OFF_MONO_LVL) ? 8'hFC : 8'hFF;
    endfunction
    function automatic logic [7:0] expv(input logic [7:0] a);
        return (a >= OFF_RDAC_RCOM && a <= OFF_SECOND_LEFT_LINE_INPUT_LLINE) ? mdl[a - 8'h47] : 8'h00;
    endfunction
    // one bus cycle; strobes stay up until the next op or an idle wait
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        #1;
        v = reg_rdata;
        if (w && a >= OFF_RDAC_RCOM && a <= OFF_SECOND_LEFT_LINE_INPUT_LLINE) begin
            mdl[a - 8'h47] = (a == OFF_MONO_LVL) ? (d & 8'hF8) : d;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a);
        op(1'h0, a, 8'h00);
        check(v & msk(a), expv(a) & msk(a));
    endtask
    task automatic wait_cyc(input int n);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic ports_chk();
        for (int i = 0; i < NUM_ROUTES; i++) begin
            check(route_cfg[i], mdl[ROUTE_OFFS[i*8+:8] - 8'h47]);
        end
        check({1'h0, rcom_level}, {1'h0, mdl[1][7:2], mdl[1][0]});
        check({3'h0, mono_level}, {3'h0, mdl[8][7:3]});
    endtask
    // reset, then every register and the route and level outputs at their reset values
    task automatic after_reset();
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        rst <= 1'h1;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        #1;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[1] = 8'h04;
        check(reg_rdata, 8'h00);
        op(1'h0, OFF_RCOM_LVL, 8'h00);
        check(v, 8'h06);
        op(1'h0, OFF_MONO_LVL, 8'h00);
        check(v, 8'h02);
        for (int a = 8'h45; a <= 8'h52; a++) rd_chk(8'(a));
        ports_chk();
    endtask
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        void'($urandom(3564));
        after_reset();
        // read straight after write, top level code
        op(1'h1, OFF_SECOND_LEFT_LINE_INPUT_MONO, 8'h85);
        rd_chk(OFF_SECOND_LEFT_LINE_INPUT_MONO);
        op(1'h1, OFF_RCOM_LVL, 8'h9C);
        rd_chk(OFF_RCOM_LVL);
        for (int k = 0; k < 80; k++) begin
            a = 8'h45 + 8'($urandom_range(0, 13));
            d = 8'($urandom);
            if (a == OFF_RCOM_LVL || a == OFF_MONO_LVL) d[7:4] = 4'($urandom_range(0, 9));
            if (a == OFF_MONO_LVL) d[2:0] = 3'h0;
            if ($urandom_range(0, 1)) op(1'h1, a, d);
            else rd_chk(a);
        end
        ports_chk();
        // left line write leaves both settle flags alone
        wait_cyc(SC + 2);
        op(1'h1, OFF_SECOND_LEFT_LINE_INPUT_LLINE, 8'h7F);
        check({6'h0, rcom_pending, mono_pending}, 8'h00);
        op(1'h1, OFF_MONO_LVL, 8'h50);
        op(1'h0, OFF_MONO_LVL, 8'h00);
        check(v, 8'h52);
        op(1'h1, OFF_RDAC_RCOM, 8'h81);
        op(1'h0, OFF_RCOM_LVL, 8'h00);
        check(v & 8'h02, 8'h02);
        wait_cyc(SC);
        op(1'h0, OFF_MONO_LVL, 8'h00);
        check(v, 8'h50);
        op(1'h0, OFF_RCOM_LVL, 8'h00);
        check(v & 8'h02, 8'h00);
        // power both outputs up, then down
        mono_pwr_req <= 1'h1;
        op(1'h1, OFF_RCOM_LVL, 8'h01);
        wait_cyc(PC + 3);
        check({6'h0, rcom_powered, mono_powered}, 8'h03);
        op(1'h0, OFF_MONO_LVL, 8'h00);
        check(v & 8'h01, 8'h01);
        mono_pwr_req <= 1'h0;
        op(1'h1, OFF_RCOM_LVL, 8'h00);
        wait_cyc(2);
        check({6'h0, rcom_powered, mono_powered}, 8'h00);
        after_reset();
        give_verdict();
    end
endmodule
